// ### pkg/phy_regs_consts.svh
// Offsets, field positions, reset values and timing figures of the bank.
`ifndef PHY_REGS_CONSTS_SVH
`define PHY_REGS_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_FAST_DROP_CONFIG 6'h2D
`define IDX_CONFIG_FOUR 6'h31
`define IDX_MAC_PARALLEL_CONTROL 6'h32
`define IDX_MAC_PARALLEL_CONTROL_TWO 6'h33
`define IDX_SERIAL_MAC_NEG_STATUS 6'h37
`define IDX_EVENT_STATUS 6'h38
`define IDX_EVENT_CLEAR 6'h39
`define IDX_EVENT_ENABLE 6'h3A

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define POS_DROP_EN_BIT 15
`define POS_DROP_1G_BIT 14
`define POS_DROP_FLAGS_LSB 8
`define POS_CONFIG_FOUR_RSV_LSB 7
`define POS_NEG_TIMER_LSB 5
`define POS_CONFIG_FOUR_FIXED_LSB 1
`define POS_MIRROR_BIT 0
`define POS_MAC_EN_BIT 7
`define POS_RX_THR_LSB 5
`define POS_TX_THR_LSB 3
`define POS_TX_DLY_BIT 1
`define POS_RX_DLY_BIT 0
`define POS_BYPASS_BIT 4
`define POS_BYPASS_DLY_BIT 3
`define POS_LOW_LAT_BIT 2
`define POS_PAGE_RX_BIT 1
`define POS_NEG_DONE_BIT 0

// ----------------------------------------------------------------
// Reset values and fixed patterns
// ----------------------------------------------------------------
`define RST_NEG_TIMER 2'h1
`define RST_MAC_EN 1'h1
`define RST_RX_THR 2'h2
`define RST_TX_THR 2'h2
`define CONFIG_FOUR_FIXED_VALUE 4'h8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ 100
`define NEG_TIME_16_MS 16
`define NEG_TIME_11_MS 11
`define NEG_TIME_800_US 800
`define NEG_TIME_2_US 2

`endif

// ### pkg/phy_regs_pkg.sv
// Types shared by the configuration register bank.
package phy_regs_pkg;

    // ----------------------------------------------------------------
    // Configuration carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic enable;
        logic gigabit;
        logic [4:0] sources;
    } rapid_drop_cfg_t;

    typedef struct packed {
        logic iface_en;
        logic [1:0] rx_fifo_half_threshold;
        logic [1:0] tx_fifo_half_threshold;
        logic tx_clk_delay;
        logic rx_clk_delay;
        logic async_fifo_bypass;
        logic async_bypass_rx_clock_delay;
        logic low_latency;
    } mac_cfg_t;

    typedef enum logic [1:0] {
        NEG_TMR_16MS = 2'h0,
        NEG_TMR_2US = 2'h1,
        NEG_TMR_800US = 2'h2,
        NEG_TMR_11MS = 2'h3
    } neg_timer_sel_t;

endpackage : phy_regs_pkg

// ### verilog/phy_link_config_registers.sv
// Link drop, mirroring and MAC interface configuration register bank.
`timescale 1ns/1ps
`include "phy_regs_consts.svh"

// How it works
// R1: Master enable turns rapid link drop on.
// R2: Gigabit select tunes rapid drop for 1000BASE-T.
// R3: Five cause flags latch on enabled drops.
// R4: Five source enables choose drop criteria.
// R5: Two-bit field picks negotiation timer duration.
// R6: Fixed field reads 1000, ignores writes.
// R7: Mirroring enable bit, resets to zero.
// R8: MAC interface enable bit, resets to one.
// R9: Receive FIFO half threshold, resets to 10.
// R10: Transmit FIFO half threshold, resets to 10.
// R11: Transmit clock delay shifts transmit clock.
// R12: Receive clock delay shifts receive clock.
// R13: Bypass bit routes around asynchronous FIFO.
// R14: Bypass delay delays receive clock at 10/100.
// R15: Low latency bit for 10/100 operation.
// R16: Page received status is read only.
// R17: Negotiation done status is read only.
// R18: Reserved read-only bits read zero; here config four bits 8:7 are writable and read back what was written.
// R19: Cause flags clear on read, then relatch.
module phy_link_config_registers
    import phy_regs_pkg::*;
#(
    parameter logic [20:0] TMR_16MS_CYC =
        21'(`NEG_TIME_16_MS * 1000 * `CLK_MHZ),
    parameter logic [20:0] TMR_11MS_CYC =
        21'(`NEG_TIME_11_MS * 1000 * `CLK_MHZ),
    parameter logic [20:0] TMR_800US_CYC =
        21'(`NEG_TIME_800_US * `CLK_MHZ)
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire logic [4:0] drop_event,
    input wire logic page_received,
    input wire logic negotiation_done,
    output rapid_drop_cfg_t rapid_drop_cfg,
    output logic rapid_drop_request,
    output logic [20:0] neg_timer_cycles,
    output logic port_mirror_enable,
    output mac_cfg_t mac_cfg,
    output logic irq
);

    localparam logic [20:0] TMR_2US_CYC =
        21'(`NEG_TIME_2_US * `CLK_MHZ);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic ack_q;
    logic [31:0] dat_q;
    logic drop_en_q;
    logic drop_1g_q;
    logic [4:0] drop_src_q;
    logic [4:0] drop_flags_q;
    logic [4:0] drop_flags_d;
    logic drop_req_q;
    logic [1:0] neg_timer_q;
    logic [20:0] tmr_cyc_q;
    logic [1:0] config_four_rsv_q;
    logic mirror_q;
    mac_cfg_t mac_q;
    logic page_rx_q;
    logic neg_done_q;
    logic [6:0] evt_stat_q;
    logic [6:0] evt_stat_d;
    logic [6:0] evt_en_q;
    logic irq_q;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire [5:0] idx = wb_adr[7:2];
    wire req = wb_cyc & wb_stb & ~ack_q;
    wire wr = req & wb_we;
    wire rd = req & ~wb_we;
    wire wr_lo = wr & wb_sel[0];
    wire wr_hi = wr & wb_sel[1];
    wire hit_drop = idx == `IDX_FAST_DROP_CONFIG;
    wire hit_config_four = idx == `IDX_CONFIG_FOUR;
    wire hit_ctl = idx == `IDX_MAC_PARALLEL_CONTROL;
    wire hit_ctl2 = idx == `IDX_MAC_PARALLEL_CONTROL_TWO;
    wire hit_neg = idx == `IDX_SERIAL_MAC_NEG_STATUS;
    wire hit_stat = idx == `IDX_EVENT_STATUS;
    wire hit_clr = idx == `IDX_EVENT_CLEAR;
    wire hit_en = idx == `IDX_EVENT_ENABLE;
    wire [7:0] wd_lo = wb_dat_w[7:0];
    wire [7:0] wd_hi = wb_dat_w[15:8];

    // ----------------------------------------------------------------
    // Read words
    // ----------------------------------------------------------------
    wire [15:0] rd_drop = {drop_en_q, drop_1g_q, 1'b0, drop_flags_q,
        3'h0, drop_src_q}; // R18
    wire [15:0] rd_config_four = {7'h00, config_four_rsv_q, neg_timer_q,
        `CONFIG_FOUR_FIXED_VALUE, mirror_q}; // R6
    wire [15:0] rd_ctl = {8'h00, mac_q.iface_en,
        mac_q.rx_fifo_half_threshold, mac_q.tx_fifo_half_threshold,
        1'b0, mac_q.tx_clk_delay, mac_q.rx_clk_delay}; // R18
    wire [15:0] rd_ctl2 = {11'h000, mac_q.async_fifo_bypass,
        mac_q.async_bypass_rx_clock_delay, mac_q.low_latency, 2'h0};
    wire [15:0] rd_neg = {14'h0000, page_rx_q, neg_done_q}; // R16 R17
    wire [15:0] rd_word =
        hit_drop ? rd_drop :
        hit_config_four ? rd_config_four :
        hit_ctl ? rd_ctl :
        hit_ctl2 ? rd_ctl2 :
        hit_neg ? rd_neg :
        hit_stat ? {9'h000, evt_stat_q} :
        hit_en ? {9'h000, evt_en_q} : 16'h0000;

    // ----------------------------------------------------------------
    // Cause flags and events
    // ----------------------------------------------------------------
    // A drop only counts when the mechanism and that source are on.
    wire [4:0] drop_hit = drop_event & drop_src_q & {5{drop_en_q}}; // R3 R4
    wire flag_rd_clr = rd & hit_drop; // R19
    // A drop landing in the cycle of the clearing read is kept.
    assign drop_flags_d = (drop_flags_q & ~{5{flag_rd_clr}}) | drop_hit;
    wire page_rise = page_received & ~page_rx_q;
    wire done_rise = negotiation_done & ~neg_done_q;
    wire [6:0] evt_set = {done_rise, page_rise, drop_hit};
    wire [6:0] evt_clr = (wr_lo & hit_clr) ? wb_dat_w[6:0] : 7'h00;
    assign evt_stat_d = (evt_stat_q & ~evt_clr) | evt_set;
    wire [6:0] evt_en_d = (wr_lo & hit_en) ? wb_dat_w[6:0] : evt_en_q;

    // ----------------------------------------------------------------
    // Timer decode
    // ----------------------------------------------------------------
    wire [20:0] tmr_cyc_d =
        (neg_timer_q == NEG_TMR_11MS) ? TMR_11MS_CYC :
        (neg_timer_q == NEG_TMR_800US) ? TMR_800US_CYC :
        (neg_timer_q == NEG_TMR_2US) ? TMR_2US_CYC :
        TMR_16MS_CYC; // R5

    // ----------------------------------------------------------------
    // Bus answer
    // ----------------------------------------------------------------
    // Every access is answered on the next cycle with clk_en high, mapped or not.
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else if (clk_en) begin
            ack_q <= req;
            dat_q <= rd ? {16'h0000, rd_word} : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------
    // Rapid link drop configuration
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            drop_en_q <= 1'b0;
            drop_1g_q <= 1'b0;
            drop_src_q <= 5'h00;
            drop_flags_q <= 5'h00;
            drop_req_q <= 1'b0;
        end else if (clk_en) begin
            if (wr_hi && hit_drop) begin
                drop_en_q <= wd_hi[`POS_DROP_EN_BIT - 8]; // R1
                drop_1g_q <= wd_hi[`POS_DROP_1G_BIT - 8]; // R2
            end
            if (wr_lo && hit_drop) begin
                drop_src_q <= wd_lo[4:0]; // R4
            end
            drop_flags_q <= drop_flags_d; // R3 R19
            drop_req_q <= |drop_hit; // R1
        end
    end

    // ----------------------------------------------------------------
    // Timer, mirroring and MAC interface fields
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            neg_timer_q <= `RST_NEG_TIMER;
            config_four_rsv_q <= 2'h0;
            mirror_q <= 1'b0;
            tmr_cyc_q <= 21'h000000;
        end else if (clk_en) begin
            if (wr_lo && hit_config_four) begin
                neg_timer_q <= wd_lo[`POS_NEG_TIMER_LSB +: 2]; // R5
                config_four_rsv_q[0] <= wd_lo[`POS_CONFIG_FOUR_RSV_LSB];
                mirror_q <= wd_lo[`POS_MIRROR_BIT]; // R7
            end
            if (wr_hi && hit_config_four) begin
                config_four_rsv_q[1] <= wd_hi[0];
            end
            tmr_cyc_q <= tmr_cyc_d; // R5
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mac_q <= '0;
            mac_q.iface_en <= `RST_MAC_EN; // R8
            mac_q.rx_fifo_half_threshold <= `RST_RX_THR; // R9
            mac_q.tx_fifo_half_threshold <= `RST_TX_THR; // R10
        end else if (clk_en) begin
            if (wr_lo && hit_ctl) begin
                mac_q.iface_en <= wd_lo[`POS_MAC_EN_BIT]; // R8
                mac_q.rx_fifo_half_threshold <=
                    wd_lo[`POS_RX_THR_LSB +: 2]; // R9
                mac_q.tx_fifo_half_threshold <=
                    wd_lo[`POS_TX_THR_LSB +: 2]; // R10
                mac_q.tx_clk_delay <= wd_lo[`POS_TX_DLY_BIT]; // R11
                mac_q.rx_clk_delay <= wd_lo[`POS_RX_DLY_BIT]; // R12
            end
            if (wr_lo && hit_ctl2) begin
                mac_q.async_fifo_bypass <= wd_lo[`POS_BYPASS_BIT]; // R13
                mac_q.async_bypass_rx_clock_delay <=
                    wd_lo[`POS_BYPASS_DLY_BIT]; // R14
                mac_q.low_latency <= wd_lo[`POS_LOW_LAT_BIT]; // R15
            end
        end
    end

    // ----------------------------------------------------------------
    // Negotiation status and interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            page_rx_q <= 1'b0;
            neg_done_q <= 1'b0;
            evt_stat_q <= 7'h00;
            evt_en_q <= 7'h00;
            irq_q <= 1'b0;
        end else if (clk_en) begin
            page_rx_q <= page_received; // R16
            neg_done_q <= negotiation_done; // R17
            evt_stat_q <= evt_stat_d;
            evt_en_q <= evt_en_d;
            // Built from next values so the line tracks status exactly.
            irq_q <= |(evt_stat_d & evt_en_d);
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign wb_ack = ack_q;
    assign wb_dat_r = dat_q;
    assign rapid_drop_cfg = '{enable: drop_en_q, gigabit: drop_1g_q,
        sources: drop_src_q};
    assign rapid_drop_request = drop_req_q;
    assign neg_timer_cycles = tmr_cyc_q;
    assign port_mirror_enable = mirror_q;
    assign mac_cfg = mac_q;
    assign irq = irq_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_drop_master_off: assert property ( // R1
        clk_en && !drop_en_q |=> !rapid_drop_request)
        else $error("Drop request raised while master enable is off.");

    a_gigabit_write: assert property ( // R2
        clk_en && wr_hi && hit_drop
        |=> rapid_drop_cfg.gigabit == $past(wb_dat_w[14]))
        else $error("Gigabit select did not take the written value.");

    a_flag_latch: assert property ( // R3
        clk_en && drop_hit != 5'h00
        |=> (drop_flags_q & $past(drop_hit)) == $past(drop_hit))
        else $error("Enabled drop cause did not latch its flag.");

    a_source_gate: assert property ( // R4
        clk_en && !flag_rd_clr && (drop_event & drop_src_q) == 5'h00
        |=> $stable(drop_flags_q))
        else $error("Cause flag changed without an enabled source.");

    a_timer_16ms: assert property ( // R5
        clk_en && neg_timer_q == 2'h0
        |=> neg_timer_cycles == TMR_16MS_CYC)
        else $error("Timer code 00 did not give the 16 ms count.");

    a_fixed_pattern: assert property ( // R6
        clk_en && rd && hit_config_four |=> wb_ack && wb_dat_r[4:1] == 4'h8)
        else $error("Fixed field did not read as 1000.");

    a_mac_enable_wr: assert property ( // R8
        clk_en && wr_lo && hit_ctl
        |=> mac_cfg.iface_en == $past(wb_dat_w[7]))
        else $error("MAC interface enable did not follow the write.");

    a_reserved_zero: assert property ( // R18
        clk_en && rd && (hit_ctl || hit_neg)
        |=> wb_dat_r[15:8] == 8'h00)
        else $error("Reserved bits did not read as zero.");

    a_flag_read_clear: assert property ( // R19
        clk_en && flag_rd_clr && drop_hit == 5'h00
        |=> drop_flags_q == 5'h00)
        else $error("Cause flags survived a read without new drops.");

    a_ack_single: assert property (
        wb_ack |=> !wb_ack)
        else $error("Acknowledge stood for more than one cycle.");

endmodule : phy_link_config_registers

// ### testbench/link_side_model.sv
// Link-side model: drop causes and serial negotiation levels.
`timescale 1ns/1ps
module link_side_model (
    input wire logic sys_clk,
    output logic [4:0] drop_event,
    output logic page_received,
    output logic negotiation_done
);
    initial begin
        drop_event = 5'h00;
        page_received = 1'b0;
        negotiation_done = 1'b0;
    end

    // One-cycle pulse, so a held level cannot hide a missed relatch.
    task automatic pulse(input logic [4:0] m);
        @(posedge sys_clk);
        drop_event <= m;
        @(posedge sys_clk);
        drop_event <= 5'h00;
    endtask : pulse

    task automatic levels(input logic p, input logic n);
        @(posedge sys_clk);
        page_received <= p;
        negotiation_done <= n;
    endtask : levels
endmodule : link_side_model

// ### testbench/phy_link_config_registers_bench.sv
// Self-checking bench for the link configuration register bank.
`timescale 1ns/1ps
`include "phy_regs_consts.svh"
module phy_link_config_registers_bench
    import phy_regs_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    localparam int TMR_TAB [4] = '{160, `NEG_TIME_2_US * `CLK_MHZ, 80, 110};
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_w = 32'h00000000;
    wire [31:0] wb_dat_r;
    wire wb_ack, rapid_drop_request, port_mirror_enable, irq;
    wire [20:0] neg_timer_cycles;
    wire [4:0] drop_event;
    wire page_received, negotiation_done;
    rapid_drop_cfg_t rapid_drop_cfg;
    mac_cfg_t mac_cfg;
    int num_errors = 0;
    int compares = 0;
    logic [31:0] exp_q [$];
    string nm_q [$];

    always #5 sys_clk = ~sys_clk;

    phy_link_config_registers #(.TMR_16MS_CYC(21'(TMR_TAB[0])),
        .TMR_11MS_CYC(21'(TMR_TAB[3])), .TMR_800US_CYC(21'(TMR_TAB[2]))
    ) dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .drop_event(drop_event), .page_received(page_received),
        .negotiation_done(negotiation_done), .rapid_drop_cfg(rapid_drop_cfg),
        .rapid_drop_request(rapid_drop_request),
        .neg_timer_cycles(neg_timer_cycles),
        .port_mirror_enable(port_mirror_enable), .mac_cfg(mac_cfg),
        .irq(irq));

    link_side_model link (.sys_clk(sys_clk), .drop_event(drop_event),
        .page_received(page_received), .negotiation_done(negotiation_done));

    // ----------------------------------------------------------------
    // Tasks and answer monitor
    // ----------------------------------------------------------------
    task automatic finish_test();
        if (num_errors == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test

    task automatic check(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    // Write answers carry zero data, so their note expects zero.
    task automatic bus(input logic we, input logic [5:0] idx,
        input logic [31:0] d, input logic [3:0] sel, input logic [31:0] e,
        input string nm);
        int n;
        exp_q.push_back(we ? 32'h00000000 : e);
        nm_q.push_back(nm);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'b00};
        wb_sel <= sel;
        wb_dat_w <= d;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (wb_ack !== 1'b1) begin
            num_errors++;
            finish_test();
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge sys_clk);
    endtask : bus

    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d, 4'h3, 32'h00000000, "write_answer");
    endtask : wr

    task automatic rd(input logic [5:0] idx, input logic [31:0] e,
        input string nm);
        bus(1'b0, idx, 32'h00000000, 4'h3, e, nm);
    endtask : rd

    always @(posedge sys_clk) begin
        if (wb_ack === 1'b1) begin
            if (exp_q.size() == 0)
                check("spurious_ack", 32'h00000000, 32'h00000001);
            else
                check(nm_q.pop_front(), exp_q.pop_front(), wb_dat_r);
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] c;
        logic [31:0] m;
        void'($urandom(42));
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(`IDX_FAST_DROP_CONFIG, 32'h00000000, "fast_drop_config");
        rd(`IDX_CONFIG_FOUR, 32'h00000030, "config_four");
        rd(`IDX_MAC_PARALLEL_CONTROL, 32'h000000D0, "mac_control");
        rd(`IDX_MAC_PARALLEL_CONTROL_TWO, 32'h00000000, "mac_two");
        rd(`IDX_SERIAL_MAC_NEG_STATUS, 32'h00000000, "neg_status");
        check("mac_cfg", 32'h00000340, 32'(mac_cfg));
        check("timer", 32'(TMR_TAB[1]), 32'(neg_timer_cycles));
        // Random writes with reserved bits set; every timer code visited.
        for (int i = 0; i < 4; i++) begin
            a = $urandom;
            a[6:5] = 2'(i);
            b = $urandom;
            c = $urandom;
            m = $urandom;
            wr(`IDX_CONFIG_FOUR, a);
            rd(`IDX_CONFIG_FOUR, (a & 32'h01E1) | 32'h0010, "config_four");
            check("timer", 32'(TMR_TAB[i]), 32'(neg_timer_cycles));
            check("mirror", 32'(a[0]), 32'(port_mirror_enable));
            wr(`IDX_FAST_DROP_CONFIG, c);
            rd(`IDX_FAST_DROP_CONFIG, c & 32'hC01F, "fast_drop");
            a = {25'h0, c[15:14], c[4:0]};
            check("drop_cfg", a, 32'(rapid_drop_cfg));
            wr(`IDX_MAC_PARALLEL_CONTROL, b);
            rd(`IDX_MAC_PARALLEL_CONTROL, b & 32'h00FB, "mac_control");
            wr(`IDX_MAC_PARALLEL_CONTROL_TWO, m);
            rd(`IDX_MAC_PARALLEL_CONTROL_TWO, m & 32'h001C, "mac_two");
            a = {22'h0, b[7:3], b[1:0], m[4:2]};
            check("mac_cfg", a, 32'(mac_cfg));
            wr(`IDX_SERIAL_MAC_NEG_STATUS, m);
            rd(`IDX_SERIAL_MAC_NEG_STATUS, 32'h00000000, "neg_status");
        end
        bus(1'b1, `IDX_FAST_DROP_CONFIG, 32'h0000FFFF, 4'h1, 32'h0, "lane");
        rd(`IDX_FAST_DROP_CONFIG, (c & 32'hC000) | 32'h1F, "lane_read");
        wr(6'h00, 32'h0000FFFF);
        rd(6'h00, 32'h00000000, "unmapped");
        rd(6'h3F, 32'h00000000, "unmapped");
        // Sources on but master off: causes must be ignored.
        wr(`IDX_FAST_DROP_CONFIG, 32'h0000001F);
        link.pulse(5'h1F);
        @(posedge sys_clk);
        check("request", 32'h0, 32'(rapid_drop_request));
        rd(`IDX_FAST_DROP_CONFIG, 32'h0000001F, "no_flags");
        wr(`IDX_FAST_DROP_CONFIG, 32'h0000C01F);
        for (int i = 0; i < 5; i++) begin
            link.pulse(5'(5'h01 << i));
            @(posedge sys_clk);
            check("request", 32'h1, 32'(rapid_drop_request));
            rd(`IDX_FAST_DROP_CONFIG, 32'hC01F | (32'h100 << i), "flag");
            rd(`IDX_FAST_DROP_CONFIG, 32'h0000C01F, "flag_cleared");
        end
        wr(`IDX_FAST_DROP_CONFIG, 32'h0000800F);
        link.pulse(5'h10);
        @(posedge sys_clk);
        check("request", 32'h0, 32'(rapid_drop_request));
        rd(`IDX_FAST_DROP_CONFIG, 32'h0000800F, "masked_source");
        // A frozen block must not latch a cause that arrives meanwhile.
        wr(`IDX_FAST_DROP_CONFIG, 32'h0000801F);
        clk_en <= 1'b0;
        link.pulse(5'h01);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        @(posedge sys_clk);
        check("frozen_request", 32'h0, 32'(rapid_drop_request));
        rd(`IDX_FAST_DROP_CONFIG, 32'h0000801F, "frozen_flags");
        // Event status, enable, clear and the level interrupt.
        wr(`IDX_EVENT_CLEAR, 32'h0000007F);
        rd(`IDX_EVENT_STATUS, 32'h00000000, "event_status");
        wr(`IDX_EVENT_ENABLE, 32'h00000060);
        rd(`IDX_EVENT_ENABLE, 32'h00000060, "event_enable");
        check("irq", 32'h0, 32'(irq));
        link.levels(1'b1, 1'b1);
        @(posedge sys_clk);
        rd(`IDX_SERIAL_MAC_NEG_STATUS, 32'h00000003, "neg_status");
        rd(`IDX_EVENT_STATUS, 32'h00000060, "event_status");
        check("irq", 32'h1, 32'(irq));
        wr(`IDX_EVENT_ENABLE, 32'h00000000);
        check("irq_masked", 32'h0, 32'(irq));
        wr(`IDX_EVENT_ENABLE, 32'h00000060);
        check("irq", 32'h1, 32'(irq));
        wr(`IDX_EVENT_CLEAR, 32'h00000060);
        rd(`IDX_EVENT_CLEAR, 32'h00000000, "event_clear");
        rd(`IDX_EVENT_STATUS, 32'h00000000, "event_status");
        check("irq_cleared", 32'h0, 32'(irq));
        finish_test();
    end
endmodule : phy_link_config_registers_bench
